//--- include/wct_pkg.sv
// Purpose: constants, types and helpers of the weigh timing block
// Assumes: settings packed decimal, weights binary
// Notes: offsets are word indices in the shared data area
package wct_pkg;
  // register word offsets
  localparam logic [7:0] OFS_INHIBIT = 8'h14;
  localparam logic [7:0] OFS_COMPARE = 8'h15;
  localparam logic [7:0] OFS_PULSE = 8'h16;
  localparam logic [7:0] OFS_JOG = 8'h17;
  localparam logic [7:0] OFS_INTERVAL = 8'h18;
  localparam logic [7:0] OFS_CONFIG = 8'h19;
  localparam logic [7:0] OFS_NET_LO = 8'h2c;
  localparam logic [7:0] OFS_NET_HI = 8'h2d;
  localparam logic [7:0] OFS_GROSS_LO = 8'h2e;
  localparam logic [7:0] OFS_GROSS_HI = 8'h2f;
  // values after reset
  localparam logic [15:0] RST_INHIBIT = 16'h0050;
  localparam logic [15:0] RST_COMPARE = 16'h0150;
  localparam logic [15:0] RST_PULSE = 16'h0300;
  localparam logic [15:0] RST_JOG = 16'h0100;
  localparam logic [15:0] RST_INTERVAL = 16'h0101;
  localparam logic [15:0] RST_CONFIG = 16'h0000;
  localparam logic [15:0] RST_LIMIT_LO = 16'h9999;
  localparam logic [15:0] RST_LIMIT_HI = 16'h0009;
  // config word fields
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_NZ_CHECK = 2;
  localparam int CFG_WV_CHECK = 3;
  localparam int CFG_JOG_ON = 4;
  localparam int CFG_SEQ_MODE = 5;
  localparam int CFG_NET = 6;
  // status word seven fields
  localparam int ST7_NET_OVER = 10;
  localparam int ST7_GROSS_OVER = 12;
  // sequence error codes
  localparam logic [3:0] ERR_NONE = 4'h0;
  localparam logic [3:0] ERR_STOP_AT_START = 4'h1;
  localparam logic [3:0] ERR_NEAR_ZERO = 4'h4;
  localparam logic [3:0] ERR_START_WEIGHT = 4'h5;
  // timing: one timer step is 10 ms
  localparam int STEP_MS = 10;
  localparam int CLK_MHZ = 125;
  localparam int STEP_CYCLES = STEP_MS * 1000 * CLK_MHZ;
  localparam int TIMERS = 4;
  localparam int T_INHIBIT = 0;
  localparam int T_COMPARE = 1;
  localparam int T_PULSE = 2;
  localparam int T_JOG = 3;

  typedef enum logic [1:0] {
    CPL_TIMER,
    CPL_TIMER_AND_STABLE,
    CPL_TIMER_OR_STABLE,
    CPL_RESERVED
  } wct_cpl_mode_t;

  typedef enum {
    ST_IDLE,
    ST_FEED,
    ST_INHIBIT,
    ST_COMPARE,
    ST_JOG
  } wct_state_t;

  function automatic logic [9:0] bcd3_to_bin(input logic [11:0] d);
    bcd3_to_bin = 10'(d[11:8] * 7'd100) + 10'(d[7:4] * 4'd10) + 10'(d[3:0]);
  endfunction

  function automatic logic [16:0] bcd5_to_bin(input logic [3:0] hi, input logic [15:0] lo);
    bcd5_to_bin = 17'(hi * 17'd10000) + 17'(lo[15:12] * 17'd1000) + 17'(lo[11:8] * 17'd100)
      + 17'(lo[7:4] * 17'd10) + 17'(lo[3:0]);
  endfunction
endpackage

//--- src/wct_timer.sv
// Purpose: decimal preset down-timer counted in 10 ms steps
// Assumes: step is a one-cycle enable from the step divider
// Notes: a preset of zero finishes one cycle after start
`timescale 1ns/1ps
`default_nettype none
module wct_timer (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // control
  input wire logic start,
  input wire logic step,
  input wire logic [11:0] preset,
  // status
  output logic busy,
  output logic done
);
  typedef struct packed {
    logic [9:0] cnt;
    logic busy;
    logic done;
  } wct_timer_st_t;

  wct_timer_st_t s_r, s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    if (start) begin
      // three decimal digits, one lsb per step: see [RL17]
      s_nxt.cnt = wct_pkg::bcd3_to_bin(preset);
      s_nxt.busy = (wct_pkg::bcd3_to_bin(preset) != 10'h000);
      s_nxt.done = (wct_pkg::bcd3_to_bin(preset) == 10'h000);
    end else if (s_r.busy && step) begin
      s_nxt.cnt = s_r.cnt - 10'h001;
      if (s_r.cnt == 10'h001) begin
        s_nxt.busy = 1'b0;
        s_nxt.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign busy = s_r.busy;
  assign done = s_r.done;
endmodule
`default_nettype wire

//--- src/wct_every_n.sv
// Purpose: fires on every Nth event, N given as two decimal digits
// Assumes: event is a one-cycle pulse
// Notes: N of zero never fires; fire is combinational with the event
`timescale 1ns/1ps
`default_nettype none
module wct_every_n (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // events
  input wire logic event_in,
  input wire logic [7:0] setting,
  // result
  output logic fire
);
  typedef struct packed {
    logic [6:0] cnt;
  } wct_every_st_t;

  wct_every_st_t s_r, s_nxt;
  logic [6:0] n;

  always_comb begin
    n = 7'(setting[7:4] * 4'd10) + 7'(setting[3:0]);
    s_nxt = s_r;
    fire = 1'b0;
    if (event_in && n != 7'h00) begin
      if (s_r.cnt + 7'h01 >= n) begin
        fire = 1'b1;
        s_nxt.cnt = 7'h00;
      end else begin
        s_nxt.cnt = s_r.cnt + 7'h01;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule
`default_nettype wire

//--- src/wct_top.sv
// Purpose: comparison timing, judgement, auto zero, start checks, jog, alarms
// Assumes: host and weight inputs share this clock
// Notes: ten millisecond step divider shared by all timers
// Behaviour
// [RL1] inhibit then compare interval suspend comparison
// [RL2] completion by selected mode, held programmable time
// [RL3] judge only at measurement completion
// [RL4] judging interval: 00 off, N every Nth
// [RL5] capture sample only on judgement
// [RL6] auto zero interval: 00 off, N every Nth
// [RL7] gross zeroes digitally, net subtracts tare
// [RL8] near zero check refuses start, error 4
// [RL9] start weight at first setpoint, error 5
// [RL10] auto jog only in sequence mode, switchable
// [RL11] under restarts final feed until jog timer
// [RL12] jog timer range 0.00 to 9.99
// [RL13] net over alarm at status bit 10
// [RL14] gross over alarm at status bit 12
// [RL15] near zero when weight at most setting
// [RL16] under when below final minus tolerance
// [RL17] timers three decimal digits, 10 ms step
// [RL18] host writes packed decimal, five digits split
`timescale 1ns/1ps
`default_nettype none
module wct_top #(
  parameter int STEP_CYCLES = wct_pkg::STEP_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // shared data area access
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] addr,
  input wire logic [15:0] wr_data,
  output logic [15:0] rd_data,
  // sequence control
  input wire logic start_req,
  input wire logic stop_req,
  input wire logic valve_switch,
  input wire logic stable,
  // weights and set values, binary
  input wire logic [16:0] net_weight,
  input wire logic [16:0] gross_weight,
  input wire logic [16:0] final_value,
  input wire logic [16:0] first_setpoint,
  input wire logic [16:0] over_tol,
  input wire logic [16:0] under_tol,
  input wire logic [16:0] near_zero_setting,
  // sequence outputs
  output logic busy,
  output logic compare_suspended,
  output logic complete_out,
  output logic final_feed_output,
  output logic [3:0] seq_error_code,
  // judgement and zeroing
  output logic judge_over,
  output logic judge_go,
  output logic judge_under,
  output logic sample_capture,
  output logic digital_zero,
  output logic tare_subtract,
  output logic near_zero,
  // status
  output logic [15:0] status_word_seven
);
  typedef struct packed {
    wct_pkg::wct_state_t state;
    logic [20:0] div;
    logic step;
    logic elapsed;
    logic [15:0] inhibit_t;
    logic [15:0] compare_t;
    logic [15:0] pulse_t;
    logic [15:0] jog_t;
    logic [15:0] interval;
    logic [15:0] config_w;
    logic [15:0] net_lo;
    logic [15:0] net_hi;
    logic [15:0] gross_lo;
    logic [15:0] gross_hi;
    logic [15:0] rd_data;
    logic [3:0] err;
    logic feed;
    logic j_over;
    logic j_go;
    logic j_under;
    logic sample;
    logic dzero;
    logic tare;
    logic nz;
    logic [15:0] st7;
  } wct_top_st_t;

  wct_top_st_t s_r, s_nxt;
  logic [wct_pkg::TIMERS-1:0] t_start, t_busy, t_done;
  logic [11:0] t_preset [wct_pkg::TIMERS];
  logic judge_event, judge_fire, az_event, az_fire;
  logic [16:0] weight, net_limit, gross_limit;
  logic is_under, is_over, cpl_cond;
  wct_pkg::wct_cpl_mode_t mode;

  assign t_preset[wct_pkg::T_INHIBIT] = s_r.inhibit_t[11:0];
  assign t_preset[wct_pkg::T_COMPARE] = s_r.compare_t[11:0];
  assign t_preset[wct_pkg::T_PULSE] = s_r.pulse_t[11:0];
  // jog duration 0.00 to 9.99 in steps: see [RL12]
  assign t_preset[wct_pkg::T_JOG] = s_r.jog_t[11:0];

  genvar gi;
  generate
    for (gi = 0; gi < wct_pkg::TIMERS; gi++) begin : g_tmr
      wct_timer u_tmr (
        .clock(clock),
        .rst(rst),
        .start(t_start[gi]),
        .step(s_r.step),
        .preset(t_preset[gi]),
        .busy(t_busy[gi]),
        .done(t_done[gi])
      );
    end
  endgenerate

  // judging interval counts completions: see [RL4]
  wct_every_n u_judge (
    .clock(clock),
    .rst(rst),
    .event_in(judge_event),
    .setting(s_r.interval[7:0]),
    .fire(judge_fire)
  );

  // auto zero interval counts started processes: see [RL6]
  wct_every_n u_az (
    .clock(clock),
    .rst(rst),
    .event_in(az_event),
    .setting(s_r.interval[15:8]),
    .fire(az_fire)
  );

  always_comb begin
    mode = wct_pkg::wct_cpl_mode_t'(s_r.config_w[wct_pkg::CFG_MODE_LSB +: 2]);
    weight = s_r.config_w[wct_pkg::CFG_NET] ? net_weight : gross_weight;
    // limits arrive as four low digits plus one high digit: see [RL18]
    net_limit = wct_pkg::bcd5_to_bin(s_r.net_hi[3:0], s_r.net_lo);
    gross_limit = wct_pkg::bcd5_to_bin(s_r.gross_hi[3:0], s_r.gross_lo);
    // sums kept one bit wider so no tolerance wraps
    is_over = {1'b0, weight} > ({1'b0, final_value} + {1'b0, over_tol});
    is_under = ({1'b0, weight} + {1'b0, under_tol}) < {1'b0, final_value}; // see [RL16]
    case (mode)
      wct_pkg::CPL_TIMER: cpl_cond = s_r.elapsed;
      wct_pkg::CPL_TIMER_AND_STABLE: cpl_cond = s_r.elapsed && stable;
      wct_pkg::CPL_TIMER_OR_STABLE: cpl_cond = s_r.elapsed || stable;
      default: cpl_cond = s_r.elapsed;
    endcase
    s_nxt = s_r;
    t_start = '0;
    judge_event = 1'b0;
    az_event = 1'b0;
    s_nxt.sample = 1'b0;
    s_nxt.dzero = 1'b0;
    s_nxt.tare = 1'b0;

    // step divider: one pulse per 10 ms
    if (s_r.div >= 21'(STEP_CYCLES - 1)) begin
      s_nxt.div = '0;
      s_nxt.step = 1'b1;
    end else begin
      s_nxt.div = s_r.div + 21'h000001;
      s_nxt.step = 1'b0;
    end

    // register writes and reads
    if (wr_en) begin
      case (addr)
        wct_pkg::OFS_INHIBIT: s_nxt.inhibit_t = wr_data;
        wct_pkg::OFS_COMPARE: s_nxt.compare_t = wr_data;
        wct_pkg::OFS_PULSE: s_nxt.pulse_t = wr_data;
        wct_pkg::OFS_JOG: s_nxt.jog_t = wr_data;
        wct_pkg::OFS_INTERVAL: s_nxt.interval = wr_data;
        wct_pkg::OFS_CONFIG: s_nxt.config_w = wr_data;
        wct_pkg::OFS_NET_LO: s_nxt.net_lo = wr_data;
        wct_pkg::OFS_NET_HI: s_nxt.net_hi = wr_data;
        wct_pkg::OFS_GROSS_LO: s_nxt.gross_lo = wr_data;
        wct_pkg::OFS_GROSS_HI: s_nxt.gross_hi = wr_data;
        default: ;
      endcase
    end
    if (rd_en) begin
      case (addr)
        wct_pkg::OFS_INHIBIT: s_nxt.rd_data = s_r.inhibit_t;
        wct_pkg::OFS_COMPARE: s_nxt.rd_data = s_r.compare_t;
        wct_pkg::OFS_PULSE: s_nxt.rd_data = s_r.pulse_t;
        wct_pkg::OFS_JOG: s_nxt.rd_data = s_r.jog_t;
        wct_pkg::OFS_INTERVAL: s_nxt.rd_data = s_r.interval;
        wct_pkg::OFS_CONFIG: s_nxt.rd_data = s_r.config_w;
        wct_pkg::OFS_NET_LO: s_nxt.rd_data = s_r.net_lo;
        wct_pkg::OFS_NET_HI: s_nxt.rd_data = s_r.net_hi;
        wct_pkg::OFS_GROSS_LO: s_nxt.rd_data = s_r.gross_lo;
        wct_pkg::OFS_GROSS_HI: s_nxt.rd_data = s_r.gross_hi;
        default: s_nxt.rd_data = 16'h0000;
      endcase
    end

    // continuous flags
    s_nxt.nz = (weight <= near_zero_setting); // see [RL15]
    s_nxt.st7 = 16'h0000;
    s_nxt.st7[wct_pkg::ST7_NET_OVER] = (net_weight > net_limit); // see [RL13]
    s_nxt.st7[wct_pkg::ST7_GROSS_OVER] = (gross_weight > gross_limit); // see [RL14]

    // compare timer end latches elapsed for the completion mode: see [RL2]
    if (t_done[wct_pkg::T_COMPARE]) begin
      s_nxt.elapsed = 1'b1;
    end

    case (s_r.state)
      wct_pkg::ST_IDLE: begin
        if (start_req) begin
          if (stop_req) begin
            s_nxt.err = wct_pkg::ERR_STOP_AT_START;
          end else if (s_r.config_w[wct_pkg::CFG_NZ_CHECK] && !s_r.nz) begin
            s_nxt.err = wct_pkg::ERR_NEAR_ZERO; // see [RL8]
          end else if (s_r.config_w[wct_pkg::CFG_WV_CHECK] &&
                       ({1'b0, weight} + {1'b0, first_setpoint}) >= {1'b0, final_value}) begin
            // the lower code wins when both checks fail
            s_nxt.err = wct_pkg::ERR_START_WEIGHT; // see [RL9]
          end else begin
            s_nxt.err = wct_pkg::ERR_NONE;
            az_event = 1'b1;
            if (az_fire) begin
              s_nxt.dzero = !s_r.config_w[wct_pkg::CFG_NET]; // see [RL7]
              s_nxt.tare = s_r.config_w[wct_pkg::CFG_NET]; // see [RL7]
            end
            s_nxt.state = wct_pkg::ST_FEED;
          end
        end
      end
      wct_pkg::ST_FEED: begin
        if (valve_switch) begin
          t_start[wct_pkg::T_INHIBIT] = 1'b1; // see [RL1]
          s_nxt.state = wct_pkg::ST_INHIBIT;
        end
      end
      wct_pkg::ST_INHIBIT: begin
        if (t_done[wct_pkg::T_INHIBIT]) begin
          t_start[wct_pkg::T_COMPARE] = 1'b1; // see [RL1]
          s_nxt.elapsed = 1'b0;
          s_nxt.state = wct_pkg::ST_COMPARE;
        end
      end
      wct_pkg::ST_COMPARE: begin
        if (cpl_cond) begin
          t_start[wct_pkg::T_PULSE] = 1'b1; // see [RL2]
          judge_event = 1'b1; // see [RL3]
          s_nxt.state = wct_pkg::ST_IDLE;
          if (judge_fire) begin
            s_nxt.j_over = is_over;
            s_nxt.j_under = is_under;
            s_nxt.j_go = !is_over && !is_under;
            // sample taken in the same cycle that a jog restarts the feed: see [RL5]
            s_nxt.sample = 1'b1;
            if (is_under && s_r.config_w[wct_pkg::CFG_JOG_ON] && s_r.config_w[wct_pkg::CFG_SEQ_MODE]) begin
              t_start[wct_pkg::T_JOG] = 1'b1; // see [RL10]
              s_nxt.feed = 1'b1; // see [RL11]
              s_nxt.state = wct_pkg::ST_JOG;
            end
          end
        end
      end
      wct_pkg::ST_JOG: begin
        if (t_done[wct_pkg::T_JOG]) begin
          s_nxt.feed = 1'b0; // see [RL11]
          t_start[wct_pkg::T_INHIBIT] = 1'b1;
          s_nxt.state = wct_pkg::ST_INHIBIT;
        end
      end
      default: s_nxt.state = wct_pkg::ST_IDLE;
    endcase

    // stop aborts the sequence and final feed (running timers keep going) and clears a pending error unless a start comes with it while idle
    if (stop_req && s_r.state != wct_pkg::ST_IDLE) begin
      s_nxt.state = wct_pkg::ST_IDLE;
      s_nxt.feed = 1'b0;
      s_nxt.err = wct_pkg::ERR_NONE;
    end else if (stop_req && !start_req) begin
      s_nxt.err = wct_pkg::ERR_NONE;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_r <= '0;
      s_r.state <= wct_pkg::ST_IDLE;
      s_r.inhibit_t <= wct_pkg::RST_INHIBIT;
      s_r.compare_t <= wct_pkg::RST_COMPARE;
      s_r.pulse_t <= wct_pkg::RST_PULSE;
      s_r.jog_t <= wct_pkg::RST_JOG;
      s_r.interval <= wct_pkg::RST_INTERVAL;
      s_r.config_w <= wct_pkg::RST_CONFIG;
      s_r.net_lo <= wct_pkg::RST_LIMIT_LO;
      s_r.net_hi <= wct_pkg::RST_LIMIT_HI;
      s_r.gross_lo <= wct_pkg::RST_LIMIT_LO;
      s_r.gross_hi <= wct_pkg::RST_LIMIT_HI;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs
  assign rd_data = s_r.rd_data;
  assign busy = (s_r.state != wct_pkg::ST_IDLE);
  // held off through inhibit and compare time
  assign compare_suspended = t_busy[wct_pkg::T_INHIBIT] || t_busy[wct_pkg::T_COMPARE]
    || (s_r.state == wct_pkg::ST_INHIBIT);
  assign complete_out = t_busy[wct_pkg::T_PULSE];
  assign final_feed_output = s_r.feed;
  assign seq_error_code = s_r.err;
  assign judge_over = s_r.j_over;
  assign judge_go = s_r.j_go;
  assign judge_under = s_r.j_under;
  assign sample_capture = s_r.sample;
  assign digital_zero = s_r.dzero;
  assign tare_subtract = s_r.tare;
  assign near_zero = s_r.nz;
  assign status_word_seven = s_r.st7;
endmodule
`default_nettype wire

//--- tb/wct_top_chk_sva.sv
// Purpose: port-level checker for the weigh timing block
// Assumes: settings mirrored from host writes
// Notes: alarms and near zero lag their cause one cycle
`timescale 1ns/1ps
`default_nettype none
module wct_top_chk (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // host writes
  input wire logic wr_en,
  input wire logic [7:0] addr,
  input wire logic [15:0] wr_data,
  // sequence
  input wire logic start_req,
  input wire logic stop_req,
  input wire logic busy,
  input wire logic complete_out,
  input wire logic final_feed_output,
  input wire logic [3:0] seq_error_code,
  input wire logic judge_under,
  input wire logic sample_capture,
  input wire logic digital_zero,
  input wire logic tare_subtract,
  input wire logic near_zero,
  input wire logic [15:0] status_word_seven,
  // weights
  input wire logic [16:0] net_weight,
  input wire logic [16:0] gross_weight,
  input wire logic [16:0] final_value,
  input wire logic [16:0] first_setpoint,
  input wire logic [16:0] near_zero_setting
);
  logic [15:0] nlo_r, nhi_r, glo_r, ghi_r, cfg_r, ivl_r;
  logic [16:0] net_lim, gross_lim, cmp_w;

  function automatic logic [16:0] dec5(input logic [3:0] h, input logic [15:0] l);
    return 17'(h * 10000 + l[15:12] * 1000 + l[11:8] * 100 + l[7:4] * 10 + l[3:0]);
  endfunction

  // settings mirror
  always_ff @(posedge clock) begin
    if (rst) begin
      nlo_r <= wct_pkg::RST_LIMIT_LO;
      glo_r <= wct_pkg::RST_LIMIT_LO;
      nhi_r <= wct_pkg::RST_LIMIT_HI;
      ghi_r <= wct_pkg::RST_LIMIT_HI;
      cfg_r <= wct_pkg::RST_CONFIG;
      ivl_r <= wct_pkg::RST_INTERVAL;
    end else if (wr_en) begin
      case (addr)
        wct_pkg::OFS_NET_LO: nlo_r <= wr_data;
        wct_pkg::OFS_NET_HI: nhi_r <= wr_data;
        wct_pkg::OFS_GROSS_LO: glo_r <= wr_data;
        wct_pkg::OFS_GROSS_HI: ghi_r <= wr_data;
        wct_pkg::OFS_CONFIG: cfg_r <= wr_data;
        wct_pkg::OFS_INTERVAL: ivl_r <= wr_data;
        default: ;
      endcase
    end
  end
  assign net_lim = dec5(nhi_r[3:0], nlo_r);
  assign gross_lim = dec5(ghi_r[3:0], glo_r);
  assign cmp_w = cfg_r[wct_pkg::CFG_NET] ? net_weight : gross_weight;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_net_over;
    status_word_seven[wct_pkg::ST7_NET_OVER] == ($past(net_weight) > $past(net_lim));
  endproperty
  a_net_over: assert property (p_net_over) else $error("net over alarm wrong");

  property p_gross_over;
    status_word_seven[wct_pkg::ST7_GROSS_OVER] == ($past(gross_weight) > $past(gross_lim));
  endproperty
  a_gross_over: assert property (p_gross_over) else $error("gross over alarm wrong");

  property p_near_zero;
    near_zero == ($past(cmp_w) <= $past(near_zero_setting));
  endproperty
  a_near_zero: assert property (p_near_zero) else $error("near zero flag wrong");

  property p_err_nz;
    start_req && !busy && !stop_req && cfg_r[2] && !near_zero && (cmp_w > near_zero_setting)
      |=> seq_error_code == wct_pkg::ERR_NEAR_ZERO && !busy;
  endproperty
  a_err_nz: assert property (p_err_nz) else $error("near zero start not refused");

  property p_err_wv;
    start_req && !busy && !stop_req && cfg_r[3] && !cfg_r[2]
      && (18'(cmp_w) + 18'(first_setpoint) >= 18'(final_value)) |=> seq_error_code == wct_pkg::ERR_START_WEIGHT;
  endproperty
  a_err_wv: assert property (p_err_wv) else $error("start weight error missing");

  property p_zero_kind;
    digital_zero || tare_subtract |-> $rose(busy) && !(digital_zero && tare_subtract)
      && tare_subtract == $past(cfg_r[wct_pkg::CFG_NET]);
  endproperty
  a_zero_kind: assert property (p_zero_kind) else $error("auto zero kind wrong");

  property p_no_judge;
    $past(ivl_r[7:0]) == 8'h00 |-> !sample_capture;
  endproperty
  a_no_judge: assert property (p_no_judge) else $error("capture with judging off");

  property p_capt_sync;
    sample_capture |-> $rose(complete_out);
  endproperty
  a_capt_sync: assert property (p_capt_sync) else $error("capture not at completion");

  property p_jog;
    $rose(final_feed_output) |-> judge_under && $past(cfg_r[4] && cfg_r[5]);
  endproperty
  a_jog: assert property (p_jog) else $error("auto jog refeed without cause");
endmodule

bind wct_top wct_top_chk u_wct_top_chk (.clock, .rst, .wr_en, .addr, .wr_data,
  .start_req, .stop_req, .busy, .complete_out, .final_feed_output, .seq_error_code, .judge_under,
  .sample_capture, .digital_zero, .tare_subtract, .near_zero, .status_word_seven, .net_weight,
  .gross_weight, .final_value, .first_setpoint, .near_zero_setting);
`default_nettype wire

//--- tb/wct_host_model.sv
// Purpose: host controller model for the shared data area
// Assumes: same clock as the block
// Notes: released lines show inverted values
`timescale 1ns/1ps
`default_nettype none
module wct_host_model (
  // clock
  input wire logic clock,
  // shared data area
  output logic wr_en,
  output logic rd_en,
  output logic [7:0] addr,
  output logic [15:0] wr_data,
  input wire logic [15:0] rd_data
);
  initial {wr_en, rd_en, addr, wr_data} = '0;
  // packed decimal words, limits split lo and hi
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge clock);
    wr_en <= 1'b0;
    addr <= ~a;
    wr_data <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clock);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd_en <= 1'b0;
    addr <= ~a;
    @(posedge clock);
    d = rd_data;
  endtask
endmodule
`default_nettype wire

//--- tb/tb_weigh_compare_timing_control.sv
// Purpose: self-checking bench for the weigh compare timing block
// Assumes: step divider shortened to 4 cycles
// Notes: pulse length allows a partial first step
`timescale 1ns/1ps
`default_nettype none
module tb_weigh_compare_timing_control;
  logic clock, rst, wr_en, rd_en, start_req, stop_req, valve_switch, stable;
  logic busy, compare_suspended, complete_out, final_feed_output, judge_go, sample_capture, digital_zero, tare_subtract;
  logic [7:0] addr;
  logic [15:0] wr_data, rd_data, status_word_seven, d;
  logic [16:0] net_weight, gross_weight, final_value, first_setpoint, over_tol, under_tol, near_zero_setting;
  logic [3:0] seq_error_code;
  int miscompares, cmp_count, cap_cnt, dz_cnt, tz_cnt, jog_cnt, pulse_cyc, c0, z0;
  logic [7:0] ra [11] = '{8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h2c, 8'h2d, 8'h2e, 8'h2f, 8'h00};
  logic [15:0] rv [11] = '{wct_pkg::RST_INHIBIT, wct_pkg::RST_COMPARE, wct_pkg::RST_PULSE, wct_pkg::RST_JOG,
    wct_pkg::RST_INTERVAL, wct_pkg::RST_CONFIG, wct_pkg::RST_LIMIT_LO, wct_pkg::RST_LIMIT_HI,
    wct_pkg::RST_LIMIT_LO, wct_pkg::RST_LIMIT_HI, 16'h0000};
  logic [16:0] an [4] = '{17'd100, 17'd101, 17'd100, 17'd101};
  logic [16:0] ag [4] = '{17'd10200, 17'd10200, 17'd10201, 17'd10201};
  logic [15:0] ae [4] = '{16'h0000, 16'h0400, 16'h1000, 16'h1400};

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  wct_host_model u_wct_host_model (.clock, .wr_en, .rd_en, .addr, .wr_data, .rd_data);
  wct_top #(.STEP_CYCLES(4)) u_wct_top (.clock, .rst, .wr_en, .rd_en, .addr, .wr_data, .rd_data, .start_req,
    .stop_req, .valve_switch, .stable, .net_weight, .gross_weight, .final_value, .first_setpoint, .over_tol,
    .under_tol, .near_zero_setting, .busy, .compare_suspended, .complete_out, .final_feed_output,
    .seq_error_code, .judge_over(), .judge_go, .judge_under(), .sample_capture, .digital_zero, .tare_subtract,
    .near_zero(), .status_word_seven);

  always @(posedge clock) begin
    if (sample_capture === 1'b1) cap_cnt++;
    if (digital_zero === 1'b1) dz_cnt++;
    if (tare_subtract === 1'b1) tz_cnt++;
    if ($rose(final_feed_output)) jog_cnt++;
  end

  task automatic chk(input string nm, input logic [16:0] e, input logic [16:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic w(input logic [7:0] a, input logic [15:0] v);
    u_wct_host_model.wr(a, v);
  endtask

  task finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // one weighing; a refeed lifts the weight to go, a hang is left to the watchdog
  task automatic run_seq;
    int n;
    @(posedge clock);
    start_req <= 1'b1;
    @(posedge clock);
    start_req <= 1'b0;
    valve_switch <= 1'b1;
    @(posedge clock);
    valve_switch <= 1'b0;
    @(posedge clock);
    chk("suspended", 17'd1, 17'(compare_suspended));
    while (busy) begin
      @(posedge clock);
      if (final_feed_output) gross_weight <= 17'd100;
    end
    while (!complete_out) @(posedge clock);
    n = 0;
    while (complete_out) begin
      @(posedge clock);
      n++;
    end
    chk("pulse_len", 17'd1, 17'(n + 3 >= pulse_cyc && n <= pulse_cyc + 2));
  endtask

  task automatic try_start(input logic eb, input logic [3:0] ee);
    @(posedge clock);
    start_req <= 1'b1;
    @(posedge clock);
    start_req <= 1'b0;
    @(posedge clock);
    chk("busy", 17'(eb), 17'(busy));
    chk("seq_err", 17'(ee), 17'(seq_error_code));
    stop_req <= 1'b1;
    @(posedge clock);
    stop_req <= 1'b0;
  endtask

  initial begin
    repeat (60000) @(posedge clock);
    miscompares++;
    finish_test;
  end

  initial begin
    {start_req, stop_req, valve_switch, stable} = '0;
    {miscompares, cmp_count, cap_cnt, dz_cnt, tz_cnt, jog_cnt} = '0;
    net_weight = 17'd0;
    gross_weight = 17'd100;
    final_value = 17'd100;
    first_setpoint = 17'd10;
    over_tol = 17'd5;
    under_tol = 17'd5;
    near_zero_setting = 17'd5;
    pulse_cyc = 1200;
    rst = 1'b1;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 11; i++) begin
      u_wct_host_model.rd(ra[i], d);
      chk("reg_reset", 17'(rv[i]), 17'(d));
    end
    w(8'h00, 16'hffff);
    u_wct_host_model.rd(8'h00, d);
    chk("unmapped", 17'd0, 17'(d));
    w(wct_pkg::OFS_NET_LO, 16'h0100);
    w(wct_pkg::OFS_NET_HI, 16'h0000);
    w(wct_pkg::OFS_GROSS_LO, 16'h0200);
    w(wct_pkg::OFS_GROSS_HI, 16'h0001);
    u_wct_host_model.rd(wct_pkg::OFS_GROSS_LO, d);
    chk("readback", 17'h00200, 17'(d));
    $display("register test done");
    for (int i = 0; i < 4; i++) begin
      net_weight <= an[i];
      gross_weight <= ag[i];
      repeat (3) @(posedge clock);
      chk("status7", 17'(ae[i]), 17'(status_word_seven));
    end
    gross_weight <= 17'd100;
    $display("alarm test done");
    stable <= 1'b1;
    for (int m = 0; m < 3; m++) begin
      w(wct_pkg::OFS_CONFIG, 16'(m));
      c0 = cap_cnt;
      z0 = dz_cnt;
      run_seq;
      chk("judge_go", 17'd1, 17'(judge_go));
      chk("captures", 17'(c0 + 1), 17'(cap_cnt));
      chk("zeroes", 17'(z0 + 1), 17'(dz_cnt));
    end
    $display("completion mode test done");
    pulse_cyc = 40;
    w(wct_pkg::OFS_PULSE, 16'h0010);
    w(wct_pkg::OFS_CONFIG, 16'h0030);
    gross_weight <= 17'd90;
    c0 = cap_cnt;
    run_seq;
    chk("jog_count", 17'd1, 17'(jog_cnt));
    chk("jog_captures", 17'(c0 + 2), 17'(cap_cnt));
    chk("judge_go", 17'd1, 17'(judge_go));
    $display("auto jog test done");
    w(wct_pkg::OFS_CONFIG, 16'h0000);
    w(wct_pkg::OFS_INTERVAL, 16'h0000);
    c0 = cap_cnt;
    z0 = dz_cnt;
    run_seq;
    chk("no_capture", 17'(c0), 17'(cap_cnt));
    chk("no_zero", 17'(z0), 17'(dz_cnt));
    w(wct_pkg::OFS_INTERVAL, 16'h0303);
    for (int k = 0; k < 3; k++) run_seq;
    chk("third_capture", 17'(c0 + 1), 17'(cap_cnt));
    chk("third_zero", 17'(z0 + 1), 17'(dz_cnt));
    $display("interval test done");
    w(wct_pkg::OFS_INTERVAL, 16'h0000);
    w(wct_pkg::OFS_CONFIG, 16'h0004);
    gross_weight <= 17'd6;
    try_start(1'b0, wct_pkg::ERR_NEAR_ZERO);
    gross_weight <= 17'd5;
    try_start(1'b1, wct_pkg::ERR_NONE);
    w(wct_pkg::OFS_CONFIG, 16'h0008);
    gross_weight <= 17'd90;
    try_start(1'b0, wct_pkg::ERR_START_WEIGHT);
    gross_weight <= 17'd89;
    try_start(1'b1, wct_pkg::ERR_NONE);
    w(wct_pkg::OFS_INTERVAL, 16'h0101);
    w(wct_pkg::OFS_CONFIG, 16'h0040);
    try_start(1'b1, wct_pkg::ERR_NONE);
    chk("tare_count", 17'd1, 17'(tz_cnt));
    $display("start check test done");
    finish_test;
  end
endmodule
`default_nettype wire
